// >>> bmwd_pkg.sv
// package for the bridge memory window decode block
package bmwd_pkg;
   // configuration space byte offsets
   localparam logic [7:0] MEM_BASE_OFS        = 8'h20;
   localparam logic [7:0] MEM_LIMIT_OFS       = 8'h22;
   localparam logic [7:0] PF_BASE_OFS         = 8'h24;
   localparam logic [7:0] PF_LIMIT_OFS        = 8'h26;
   localparam logic [7:0] PF_BASE_UPPER_OFS   = 8'h28;
   localparam logic [7:0] PF_LIMIT_UPPER_OFS  = 8'h2c;
   // field layout
   localparam int         BOUND_MSB           = 15;
   localparam int         BOUND_LSB           = 4;
   localparam int         BOUND_W             = 12;
   localparam int         LOW_ADDR_W          = 20;
   // reset and fixed values
   localparam logic [11:0] BOUND_RST          = 12'h000;
   localparam logic [31:0] UPPER_RST          = 32'h0000_0000;
   localparam logic [3:0]  MEM_LOW_NIBBLE     = 4'h0;
   localparam logic [3:0]  WIDE_ADDR_NIBBLE   = 4'h1;
   localparam logic [19:0] LOW_BITS_BASE      = 20'h00000;
   localparam logic [19:0] LOW_BITS_LIMIT     = 20'hfffff;
endpackage

// >>> bmwd_window_decode.sv
// configuration registers and address window checks for downstream memory forwarding
`timescale 1ns/1ns
module bmwd_window_decode (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   input  wire logic [63:0] txn_addr,
   output logic             mem_window_hit,
   output logic             prefetch_window_hit,
   output logic             forward_downstream
);
   import bmwd_pkg::*;

   logic [11:0] mem_window_low_bound_ff;
   logic [11:0] mem_window_high_bound_ff;
   logic [11:0] prefetch_window_low_bound_ff;
   logic [11:0] prefetch_window_high_bound_ff;
   logic [31:0] pf_base_upper_ff;
   logic [31:0] pf_limit_upper_ff;
   logic [31:0] cfg_rdata_ff;
   logic        mem_hit_ff;
   logic        pf_hit_ff;

   // dword-aligned decode
   wire logic [7:0]  dw_addr      = {cfg_addr[7:2], 2'b00};
   wire logic        sel_mem      = (dw_addr == MEM_BASE_OFS);
   wire logic        sel_pf       = (dw_addr == PF_BASE_OFS);
   wire logic        sel_pf_up_b  = (dw_addr == PF_BASE_UPPER_OFS);
   wire logic        sel_pf_up_l  = (dw_addr == PF_LIMIT_UPPER_OFS);

   // byte merge helper for 12-bit fields held in bits 15:4 of a half-word
   function automatic logic [11:0] merge_bound(input logic [11:0] cur,
                                               input logic [15:0] wd,
                                               input logic [1:0]  be);
      logic [11:0] r;
      r = cur;
      if (be[0]) begin
         r[3:0] = wd[7:4];
      end
      if (be[1]) begin
         r[11:4] = wd[15:8];
      end
      return r;
   endfunction

   function automatic logic [31:0] merge_word(input logic [31:0] cur,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
      logic [31:0] r;
      r = cur;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // per-dword write strobes; low nibbles are not stored
   wire logic        wr_mem       = cfg_wr & sel_mem;
   wire logic        wr_pf        = cfg_wr & sel_pf;
   wire logic        wr_pf_up_b   = cfg_wr & sel_pf_up_b;
   wire logic        wr_pf_up_l   = cfg_wr & sel_pf_up_l;

   // merged next values, byte enables honoured per lane
   wire logic [11:0] nxt_mem_low  = merge_bound(mem_window_low_bound_ff,
                                                cfg_wdata[15:0], cfg_be[1:0]);
   wire logic [11:0] nxt_mem_high = merge_bound(mem_window_high_bound_ff,
                                                cfg_wdata[31:16], cfg_be[3:2]);
   wire logic [11:0] nxt_pf_low   = merge_bound(prefetch_window_low_bound_ff,
                                                cfg_wdata[15:0], cfg_be[1:0]);
   wire logic [11:0] nxt_pf_high  = merge_bound(prefetch_window_high_bound_ff,
                                                cfg_wdata[31:16], cfg_be[3:2]);
   wire logic [31:0] nxt_pf_up_b  = merge_word(pf_base_upper_ff, cfg_wdata, cfg_be);
   wire logic [31:0] nxt_pf_up_l  = merge_word(pf_limit_upper_ff, cfg_wdata, cfg_be);

   // memory window base field
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         mem_window_low_bound_ff <= BOUND_RST;
      end else if (wr_mem) begin
         mem_window_low_bound_ff <= nxt_mem_low;
      end
   end

   // memory window limit field
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         mem_window_high_bound_ff <= BOUND_RST;
      end else if (wr_mem) begin
         mem_window_high_bound_ff <= nxt_mem_high;
      end
   end

   // prefetch window base field
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prefetch_window_low_bound_ff <= BOUND_RST;
      end else if (wr_pf) begin
         prefetch_window_low_bound_ff <= nxt_pf_low;
      end
   end

   // prefetch window limit field
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prefetch_window_high_bound_ff <= BOUND_RST;
      end else if (wr_pf) begin
         prefetch_window_high_bound_ff <= nxt_pf_high;
      end
   end

   // prefetch base upper word
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pf_base_upper_ff <= UPPER_RST;
      end else if (wr_pf_up_b) begin
         pf_base_upper_ff <= nxt_pf_up_b;
      end
   end

   // prefetch limit upper word
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pf_limit_upper_ff <= UPPER_RST;
      end else if (wr_pf_up_l) begin
         pf_limit_upper_ff <= nxt_pf_up_l;
      end
   end

   // read views
   wire logic [15:0] mem_base_view  = {mem_window_low_bound_ff, MEM_LOW_NIBBLE};
   wire logic [15:0] mem_limit_view = {mem_window_high_bound_ff, MEM_LOW_NIBBLE};
   wire logic [15:0] pf_base_view   = {prefetch_window_low_bound_ff, WIDE_ADDR_NIBBLE};
   wire logic [15:0] pf_limit_view  = {prefetch_window_high_bound_ff, WIDE_ADDR_NIBBLE};
   // dword read words
   wire logic [31:0] mem_dword      = {mem_limit_view, mem_base_view};
   wire logic [31:0] pf_dword       = {pf_limit_view, pf_base_view};
   wire logic [31:0] nxt_cfg_rdata  = sel_mem     ? mem_dword :
                                      sel_pf      ? pf_dword :
                                      sel_pf_up_b ? pf_base_upper_ff :
                                      sel_pf_up_l ? pf_limit_upper_ff :
                                                    32'h0000_0000;

   // full window bounds
   wire logic [31:0] mem_lo = {mem_window_low_bound_ff, LOW_BITS_BASE};
   wire logic [31:0] mem_hi = {mem_window_high_bound_ff, LOW_BITS_LIMIT};
   wire logic [63:0] pf_lo  = {pf_base_upper_ff, prefetch_window_low_bound_ff,
                               LOW_BITS_BASE};
   wire logic [63:0] pf_hi  = {pf_limit_upper_ff, prefetch_window_high_bound_ff,
                               LOW_BITS_LIMIT};

   // address halves
   wire logic [31:0] txn_high32 = txn_addr[63:32];
   wire logic [31:0] txn_low32  = txn_addr[31:0];

   // inclusive compares; an inverted window never opens
   wire logic mem_open     = (mem_lo <= mem_hi);
   wire logic pf_open      = (pf_lo <= pf_hi);

   wire logic mem_addr_32  = (txn_high32 == 32'h0000_0000);
   wire logic mem_above_lo = (txn_low32 >= mem_lo);
   wire logic mem_below_hi = (txn_low32 <= mem_hi);
   wire logic pf_above_lo  = (txn_addr >= pf_lo);
   wire logic pf_below_hi  = (txn_addr <= pf_hi);

   // memory window match for 32-bit addresses
   wire logic nxt_mem_hit  = mem_open && mem_addr_32 && mem_above_lo && mem_below_hi;
   // prefetch window match over the full 64-bit address
   wire logic nxt_pf_hit   = pf_open && pf_above_lo && pf_below_hi;

   // registered read data
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cfg_rdata_ff <= 32'h0000_0000;
      end else begin
         cfg_rdata_ff <= nxt_cfg_rdata;
      end
   end

   // registered memory window match
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         mem_hit_ff <= 1'b0;
      end else begin
         mem_hit_ff <= nxt_mem_hit;
      end
   end

   // registered prefetch window match
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pf_hit_ff <= 1'b0;
      end else begin
         pf_hit_ff <= nxt_pf_hit;
      end
   end

   // registered outputs
   assign cfg_rdata           = cfg_rdata_ff;
   assign mem_window_hit      = mem_hit_ff;
   assign prefetch_window_hit = pf_hit_ff;
   // forward whenever either window matched
   assign forward_downstream  = mem_hit_ff | pf_hit_ff;
endmodule

// >>> bmwd_window_decode_sva.sv
// assertion checker for the window decode ports
`timescale 1ns/1ns
module bmwd_window_decode_sva (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        cfg_wr,
   input wire logic [7:0]  cfg_addr,
   input wire logic [3:0]  cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic [63:0] txn_addr,
   input wire logic        mem_window_hit,
   input wire logic        prefetch_window_hit,
   input wire logic        forward_downstream
);
   wire [5:0] sel = cfg_addr[7:2];
   wire [1:0] hits = {mem_window_hit, prefetch_window_hit};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence wr_at(logic [5:0] d);
      cfg_wr && cfg_be == 4'hf && sel == d ##1 $stable(cfg_addr); endsequence
   a_fwd_or: assert property (forward_downstream == |hits) else $error("fwd");
   a_pf_ro: assert property (sel == 6'h09 |=> cfg_rdata[3:0] == 4'h1)
      else $error("ro");
   a_unmap_rd: assert property (sel[5:2] != 4'h2 |=> cfg_rdata == 32'h0)
      else $error("unmapped");
   a_mem_wide: assert property (txn_addr[63:32] != 32'h0 |=> !mem_window_hit)
      else $error("wide");
   a_hit_hold: assert property ($stable(txn_addr) && !cfg_wr && $past(nrst)
      |=> $stable(hits)) else $error("hold");
   a_mem_rw: assert property (wr_at(6'h08) |=>
      cfg_rdata == ($past(cfg_wdata, 2) & 32'hfff0fff0)) else $error("mem");
   a_pf_rw: assert property (wr_at(6'h09) |=>
      cfg_rdata == ($past(cfg_wdata, 2) & 32'hfff0fff0 | 32'h00010001)) else $error("pf");
   a_up_rw: assert property ((wr_at(6'h0a) or wr_at(6'h0b)) |=>
      cfg_rdata == $past(cfg_wdata, 2)) else $error("upper");
   c_mem: cover property (hits == 2'b10);
   c_pf: cover property (hits == 2'b01);
   c_both: cover property (hits == 2'b11);
endmodule
bind bmwd_window_decode bmwd_window_decode_sva i_sva (.*);

// >>> bmwd_window_decode_tb.sv
// testbench for the window decode block
`timescale 1ns/1ns
module bmwd_window_decode_tb;
   logic        mclk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0;
   logic [7:0]  cfg_addr = 8'h0;
   logic [3:0]  cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
   logic [63:0] txn_addr = 64'h0;
   logic        mem_window_hit, prefetch_window_hit, forward_downstream;
   int          n_mismatch = 0, n_checks = 0;
   always #10 mclk = ~mclk;
   bmwd_window_decode i_dut (.*);
   // write, then read back the same dword while checking both window flags
   task op(logic [7:0] a, logic [3:0] be, logic [31:0] d, logic [63:0] t, logic [33:0] e);
      @(posedge mclk) {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, be, d};
      @(posedge mclk) {cfg_wr, txn_addr} <= {1'b0, t};
      @(posedge mclk) #1 n_checks++;
      if ({cfg_rdata, mem_window_hit, prefetch_window_hit} !== e ||
          forward_downstream !== (e[1] | e[0])) begin
         n_mismatch++;
         $display("CHECK FAILED %0t dword %h", $time, a);
      end
   endtask
   task summarize(int late);
      n_mismatch += late;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial #20000 summarize(1);
   initial begin
      #390 nrst <= 1'b1;
      op(8'h24, 4'h0, 32'h0, 64'hfffff, {32'h00010001, 2'b11});
      op(8'h20, 4'hf, 32'hffffffff, 64'hffffffff, {32'hfff0fff0, 2'b10});
      op(8'h20, 4'h3, 32'h10, 64'h100000, {32'hfff00010, 2'b10});
      op(8'h20, 4'hc, 32'hf00000, 64'hffffff, {32'h00f00010, 2'b10});
      op(8'h30, 4'hf, 32'hffffffff, 64'hfffff, {32'h0, 2'b01});
      $display("test memory window done");
      op(8'h28, 4'hf, 32'h1, 64'h100100000, {32'h1, 2'b00});
      op(8'h2c, 4'hf, 32'h1, 64'h100000000, {32'h1, 2'b01});
      op(8'h24, 4'hf, 32'h200010, 64'h1002fffff, {32'h00210011, 2'b01});
      op(8'h24, 4'h0, 32'h0, 64'h1000fffff, {32'h00210011, 2'b00});
      op(8'h20, 4'hf, 32'h100020, 64'h150000, {32'h00100020, 2'b00});
      $display("test prefetch window done");
      summarize(0);
   end
endmodule
